// >>> pbr_device.sv
// Power unit end: button mask, shutdown and converter registers
// Notes on behaviour
// - Enable writes of 1 set button enables
// - Disable writes of 1 clear button enables
// - Mask register reads enables, reset zero
// - Host waits three slow clocks after writes
// - Shutdown bit 0 write shuts chip down
// - Step-up command bit 0 starts/stops converter
// - Step-up threshold field bits 3:0, reset 1011b
// - Host sets step-up threshold near 1A
// - Step-up voltage codes 010100 to 101000 only
// - Host keeps step-up voltage above input
// - Step-down control bit 0 starts/stops converter
// - Step-down bit 1 selects bypass
// - Step-down threshold field bits 3:0
// - Step-down mode field bits 5:4, reset 00
// - Step-down bit 6 power-up style, reset 1
// - Step-down bit 7 off output float, reset 1
// - Enable and voltage resets are variant constants
// - Interrupt pin is active low
`timescale 1ns/1ps
`include "pbr_map.svh"
module pbr_device
  import pbr_pkg::*;
#(
  // Variant startup values; each variant fixes its own
  parameter logic       SU_EN_RST   = `PBR_RST_SU_EN,
  parameter logic [5:0] SU_VOLT_RST = `PBR_RST_SU_VOLT,
  parameter logic       SD_EN_RST   = `PBR_RST_SD_EN
) (
  // Clock, reset and freeze
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Register link toward the host
  pbr_link_if.dev          link,
  // Request level from the interrupt controller outside this block
  input  wire logic        i_irq_pending,
  // Chip and step-up levels
  output logic             o_shutdown,
  output logic             o_stepup_en,
  output logic [3:0]       o_stepup_oc,
  output logic [5:0]       o_stepup_volt_code,
  // Step-down levels
  output logic             o_stepdown_en,
  output logic             o_stepdown_bypass,
  output logic [3:0]       o_stepdown_oc,
  output pbr_sd_mode_type  o_stepdown_mode,
  output logic             o_stepdown_powerup,
  output logic             o_stepdown_off_float,
  // Button enables, bit 1 high and bit 0 low
  output logic [1:0]       o_button_irq_mask
);
  // Decoded strobes from the link
  logic       wr;             // Write strobe
  logic       rd;             // Read strobe
  // Programmable state, one register per concern
  logic [1:0] btn_mask;       // Button high/low enables
  logic       su_en;          // Step-up run
  logic [3:0] su_oc;          // Step-up threshold code
  logic [5:0] su_volt;        // Step-up voltage code
  logic [1:0] sd_ctrl;        // Step-down bypass and run
  logic [7:0] sd_cfg;         // Step-down configuration
  logic       shutdown;       // Latched shutdown request
  // Read path
  logic [7:0] next_rdata;     // Read mux

  // A strobe lasts one cycle, so each write lands exactly once
  assign wr = link.req & link.we;
  assign rd = link.req & ~link.we;

  // Button enables: set and clear resolved in one step
  // The two addresses never meet in one cycle, so no set/clear race
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // Both interrupts start disabled
      btn_mask <= 2'h0;
    end else if (i_ce && wr) begin
      if (link.addr == `PBR_ADDR_BTN_EN) begin
        // Ones set bits; zeros leave them alone
        btn_mask <= btn_mask | link.wdata[1:0];
      end else if (link.addr == `PBR_ADDR_BTN_DIS) begin
        // Ones clear bits; zeros leave them alone
        btn_mask <= btn_mask & ~link.wdata[1:0];
      end
    end
  end

  // Shutdown is sticky: once requested the chip stays down until reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shutdown <= 1'b0;
    end else if (i_ce && wr && link.addr == `PBR_ADDR_SHUTDOWN
                 && link.wdata[`PBR_BIT_LOW]) begin
      // Only bit 0 counts; a zero there is ignored
      shutdown <= 1'b1;
    end
  end

  // Step-up run bit; reset level belongs to the variant
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      su_en <= SU_EN_RST;
    end else if (i_ce && wr && link.addr == `PBR_ADDR_SU_CMD) begin
      // Bit 0 is taken as written: one runs, zero stops
      su_en <= link.wdata[`PBR_BIT_EN];
    end
  end

  // Step-up overcurrent code; the upper four bits are not stored
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // Reset threshold is high; the host lowers it at startup
      su_oc <= 4'(`PBR_RST_SU_CFG);
    end else if (i_ce && wr && link.addr == `PBR_ADDR_SU_CFG) begin
      // Codes past the table are kept as given; the host keeps them out
      su_oc <= link.wdata[3:0];
    end
  end

  // Step-up output voltage code
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      su_volt <= SU_VOLT_RST;
    end else if (i_ce && wr && link.addr == `PBR_ADDR_SU_VOLT) begin
      // Forbidden low codes are dropped so the output never collapses
      if (link.wdata[5:0] >= `PBR_SU_VOLT_MIN) begin
        su_volt <= link.wdata[5:0];
      end
    end
  end

  // Step-down run and bypass bits
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // Bypass starts off so the output regulates from power-up
      sd_ctrl <= {1'b0, SD_EN_RST};
    end else if (i_ce && wr && link.addr == `PBR_ADDR_SD_CTRL) begin
      // Both bits are taken as written
      sd_ctrl <= link.wdata[1:0];
    end
  end

  // Step-down configuration: threshold, mode, power-up style, off state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // Automatic mode, slow start, floating output when off
      sd_cfg <= `PBR_RST_SD_CFG;
    end else if (i_ce && wr && link.addr == `PBR_ADDR_SD_CFG) begin
      // All eight bits are live, so the byte is kept whole
      sd_cfg <= link.wdata;
    end
  end

  // Read mux; write-only and unmapped addresses read zero
  // Settles on any address; only a read strobe samples it
  always_comb begin
    case (link.addr)
      `PBR_ADDR_BTN_MASK: next_rdata = {6'h00, btn_mask};
      `PBR_ADDR_SU_CMD:   next_rdata = {7'h00, su_en};
      `PBR_ADDR_SU_CFG:   next_rdata = {4'h0, su_oc};
      `PBR_ADDR_SU_VOLT:  next_rdata = {2'h0, su_volt};
      `PBR_ADDR_SD_CTRL:  next_rdata = {6'h00, sd_ctrl};
      `PBR_ADDR_SD_CFG:   next_rdata = sd_cfg;
      default:            next_rdata = 8'h00;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      link.rdata  <= 8'h00;
      link.rvalid <= 1'b0;
    end else if (i_ce) begin
      // Valid follows the strobe by exactly one cycle
      link.rvalid <= rd;
      if (rd) begin
        // Data is kept between reads so a late look still sees it
        link.rdata <= next_rdata;
      end
    end
  end

  // Interrupt pin; request supplied by the global controller outside
  // Registered so a decode glitch never reaches the host
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // Released pin means no request
      link.irq_n_out <= 1'b1;
    end else if (i_ce) begin
      link.irq_n_out <= ~i_irq_pending;
    end
  end

  // All outputs come straight from registers
  // Chip and step-up levels
  assign o_shutdown           = shutdown;
  assign o_stepup_en          = su_en;
  assign o_stepup_oc          = su_oc;
  assign o_stepup_volt_code   = su_volt;
  // Step-down levels
  assign o_stepdown_en        = sd_ctrl[`PBR_BIT_EN];
  assign o_stepdown_bypass    = sd_ctrl[`PBR_BIT_BYPASS];
  assign o_stepdown_oc        = sd_cfg[3:0];
  assign o_stepdown_mode      = pbr_sd_mode_type'(sd_cfg[5:4]);
  assign o_stepdown_powerup   = sd_cfg[6];
  assign o_stepdown_off_float = sd_cfg[7];
  // Button enables
  assign o_button_irq_mask    = btn_mask;
endmodule

// >>> pbr_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PBR_MAP_SVH
`define PBR_MAP_SVH
`define PBR_ADDR_BTN_EN      8'h04
`define PBR_ADDR_BTN_DIS     8'h05
`define PBR_ADDR_BTN_MASK    8'h06
`define PBR_ADDR_SHUTDOWN    8'h07
`define PBR_ADDR_SU_CMD      8'h10
`define PBR_ADDR_SU_CFG      8'h11
`define PBR_ADDR_SU_VOLT     8'h12
`define PBR_ADDR_SD_CTRL     8'h13
`define PBR_ADDR_SD_CFG      8'h14
`define PBR_BIT_LOW          0
`define PBR_BIT_HIGH         1
`define PBR_BIT_EN           0
`define PBR_BIT_BYPASS       1
`define PBR_RST_SU_CFG       8'h0B
`define PBR_RST_SD_CFG       8'hC8
`define PBR_RST_SU_EN        1'h1
`define PBR_RST_SU_VOLT      6'h14
`define PBR_RST_SD_EN        1'h1
`define PBR_SU_VOLT_MIN      6'h14
`define PBR_SU_VOLT_MAX      6'h28
`define PBR_SU_OC_1A         4'h1
`define PBR_SLOW_CLK_HZ      15000
`define PBR_CLK_HZ           40000000
`define PBR_WAIT_SLOW_CYC    3
`define PBR_WAIT_CYC         ((`PBR_WAIT_SLOW_CYC*`PBR_CLK_HZ+`PBR_SLOW_CLK_HZ-1)/`PBR_SLOW_CLK_HZ)
`endif

// >>> pbr_pkg.sv
// Types shared by both ends of the register link
package pbr_pkg;
  typedef enum logic [1:0] {
    PBR_MODE_AUTO = 2'b00,
    PBR_MODE_PWM  = 2'b01,
    PBR_MODE_SKIP = 2'b10,
    PBR_MODE_PASS = 2'b11
  } pbr_sd_mode_type;
  typedef enum logic [1:0] {
    PBR_H_IDLE  = 2'b00,
    PBR_H_ISSUE = 2'b01,
    PBR_H_WAIT  = 2'b10
  } pbr_host_state_type;
endpackage

// >>> pbr_link_if.sv
// Register access link between host and power unit, plus interrupt pin
`timescale 1ns/1ps
interface pbr_link_if;
  logic       req;       // Access strobe, one cycle
  logic       we;        // Write when high
  logic [7:0] addr;      // Register address
  logic [7:0] wdata;     // Write data
  logic [7:0] rdata;     // Read data, valid cycle after read strobe
  logic       rvalid;    // Read data valid pulse
  logic       irq_n_out; // Interrupt, active low
  modport dev  (input req, we, addr, wdata, output rdata, rvalid, irq_n_out);
  modport host (output req, we, addr, wdata, input rdata, rvalid, irq_n_out);
endinterface

// >>> pbr_host.sv
// Host end: issues register accesses and keeps write spacing
`timescale 1ns/1ps
`include "pbr_map.svh"
module pbr_host
  import pbr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  pbr_link_if.host         link,
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_we,
  input  wire logic [7:0]  i_cmd_addr,
  input  wire logic [7:0]  i_cmd_wdata,
  output logic             o_cmd_ready,
  output logic [7:0]       o_rsp_data,
  output logic             o_rsp_valid,
  output logic             o_error,
  output logic             o_irq
);
  localparam int WAIT_CYC = `PBR_WAIT_CYC; // Slow-clock spacing in fast cycles
  pbr_host_state_type state;  // Sequencer state
  logic [12:0]        wait_cnt; // Spacing counter
  logic               bad_cmd;  // Command breaks a host obligation

  // Forbidden step-up codes and a >1A startup threshold are refused here
  assign bad_cmd = i_cmd_we &&
    ((i_cmd_addr == `PBR_ADDR_SU_VOLT &&
      (i_cmd_wdata[5:0] < `PBR_SU_VOLT_MIN || i_cmd_wdata[5:0] > `PBR_SU_VOLT_MAX))
     || (i_cmd_addr == `PBR_ADDR_SU_CFG && i_cmd_wdata[3:0] > `PBR_SU_OC_1A));
  assign o_cmd_ready = (state == PBR_H_IDLE);
  assign o_irq = ~link.irq_n_out;

  // Request sequencer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state      <= PBR_H_IDLE;
      wait_cnt   <= 13'h0000;
      link.req   <= 1'b0;
      link.we    <= 1'b0;
      link.addr  <= 8'h00;
      link.wdata <= 8'h00;
      o_error    <= 1'b0;
    end else if (i_ce) begin
      link.req <= 1'b0;
      case (state)
        PBR_H_IDLE: begin
          if (i_cmd_valid) begin
            o_error <= bad_cmd;
            if (!bad_cmd) begin
              link.req   <= 1'b1;
              link.we    <= i_cmd_we;
              link.addr  <= i_cmd_addr;
              link.wdata <= i_cmd_wdata;
              state      <= PBR_H_ISSUE;
            end
          end
        end
        PBR_H_ISSUE: begin
          // Writes hold off the next access; reads wait for the answer
          if (link.we) begin
            wait_cnt <= 13'(WAIT_CYC);
            state    <= PBR_H_WAIT;
          end else if (link.rvalid) begin
            state <= PBR_H_IDLE;
          end
        end
        PBR_H_WAIT: begin
          if (wait_cnt <= 13'h0001) begin
            state <= PBR_H_IDLE;
          end
          wait_cnt <= wait_cnt - 13'h0001;
        end
        default: state <= PBR_H_IDLE;
      endcase
    end
  end

  // Read answer capture
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rsp_data  <= 8'h00;
      o_rsp_valid <= 1'b0;
    end else if (i_ce) begin
      o_rsp_valid <= link.rvalid;
      if (link.rvalid) begin
        o_rsp_data <= link.rdata;
      end
    end
  end
endmodule

// >>> pbr_link_properties.sv
// Checker for traffic on the host to power unit register link
`timescale 1ns/1ps
`include "pbr_map.svh"
module pbr_link_properties (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       irq_n_out
);
  localparam int WAIT = `PBR_WAIT_CYC;
  logic [13:0] gap;  // Cycles since last write, saturates
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Starts saturated so the first access after reset is legal
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) gap <= 14'(WAIT);
    else if (req && we) gap <= 14'h0000;
    else if (gap < 14'(WAIT)) gap <= gap + 14'h0001;
  end
  sequence s_rd(logic [7:0] a);
    req && !we && addr == a;
  endsequence
  a_read_answer: assert property (req && !we |=> rvalid)
    else $error("read strobe not answered");
  a_rvalid_cause: assert property (rvalid |-> $past(req) && !$past(we))
    else $error("read data without read strobe");
  a_rdata_holds: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved between reads");
  a_mask_upper: assert property (s_rd(8'h06) |=> rdata[7:2] == 6'h00)
    else $error("mask read has unused bits set");
  a_wo_zero: assert property (s_rd(8'h05) |=> rdata == 8'h00)
    else $error("write-only read not zero");
  a_volt_legal: assert property (s_rd(8'h12) |=> rdata >= 8'h14 && rdata <= 8'h28)
    else $error("step-up voltage code out of range");
  a_no_bad_volt: assert property (req && we && addr == 8'h12 |-> wdata >= 8'h14 && wdata <= 8'h28)
    else $error("forbidden voltage code sent");
  a_oc_startup: assert property (req && we && addr == 8'h11 |-> wdata[3:0] <= 4'h1)
    else $error("step-up threshold above 1 A");
  a_write_gap: assert property (req |-> gap >= 14'(WAIT - 1))
    else $error("access too soon after write");
  a_irq_release: assert property ($fell(i_rst) |-> irq_n_out)
    else $error("interrupt low out of reset");
endmodule

// >>> pmu_button_and_regulator_regs_test.sv
// Bench driving the host command side and watching the power unit
`timescale 1ns/1ps
module pmu_button_and_regulator_regs_test;
  import pbr_pkg::*;
  logic            i_clk = 1'b0;
  logic            i_rst = 1'b1;
  logic            pend  = 1'b0;  // Outside interrupt request
  logic            ce    = 1'b1;  // Clock enable to both ends
  logic            v     = 1'b0;  // Command valid
  logic            w     = 1'b0;
  logic [7:0]      a     = 8'h00;
  logic [7:0]      d     = 8'h00;
  logic [7:0]      rd, rsp;
  logic            shut, su_en, sd_en, bypass_select, pwr, flt, irq, rsp_v, rdy, err;
  logic [3:0]      su_oc, sd_oc;
  logic [5:0]      su_v;
  logic [1:0]      msk;
  pbr_sd_mode_type mode;
  int              n_fail   = 0;
  int              n_checks = 0;
  pbr_link_if link ();
  pbr_device i_pbr_device (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .link(link),
    .i_irq_pending(pend), .o_shutdown(shut), .o_stepup_en(su_en), .o_stepup_oc(su_oc),
    .o_stepup_volt_code(su_v), .o_stepdown_en(sd_en), .o_stepdown_bypass(bypass_select),
    .o_stepdown_oc(sd_oc), .o_stepdown_mode(mode), .o_stepdown_powerup(pwr),
    .o_stepdown_off_float(flt), .o_button_irq_mask(msk));
  pbr_host i_pbr_host (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .link(link),
    .i_cmd_valid(v), .i_cmd_we(w), .i_cmd_addr(a), .i_cmd_wdata(d), .o_cmd_ready(rdy),
    .o_rsp_data(rsp), .o_rsp_valid(rsp_v), .o_error(err), .o_irq(irq));
  pbr_link_properties i_pbr_link_properties (.i_clk(i_clk), .i_rst(i_rst), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .rvalid(link.rvalid), .irq_n_out(link.irq_n_out));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One command; waits for the host to go idle, which covers write spacing
  task automatic access(input logic wr, input logic [7:0] ad, dt);
    int k;
    k = 0;
    rd = 8'hXX;
    @(posedge i_clk);
    v <= 1'b1;
    w <= wr;
    a <= ad;
    d <= dt;
    @(posedge i_clk);
    v <= 1'b0;
    do begin
      @(posedge i_clk);
      #1;
      if (rsp_v === 1'b1) rd = rsp;
      k++;
    end while (rdy !== 1'b1 && k < 9000);
    if (k >= 9000) n_fail++;
  endtask
  task automatic rchk(input string nm, input logic [7:0] ad, exp);
    access(1'b0, ad, 8'h00);
    check(nm, rd, exp);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well past the eight spaced writes
  initial begin
    #(25 * 95000);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    rchk("mask", 8'h06, 8'h00);
    rchk("su_cmd", 8'h10, 8'h01);
    rchk("su_cfg", 8'h11, 8'h0B);
    rchk("su_volt", 8'h12, 8'h14);
    rchk("sd_ctrl", 8'h13, 8'h01);
    rchk("sd_cfg", 8'h14, 8'hC8);
    rchk("dis_wo", 8'h05, 8'h00);
    rchk("unmapped", 8'h20, 8'h00);
    check("shut0", 8'(shut), 8'h00);
    access(1'b1, 8'h04, 8'h03);
    rchk("mask_en", 8'h06, 8'h03);
    access(1'b1, 8'h05, 8'h01);
    check("mask_pin", 8'(msk), 8'h02);
    access(1'b1, 8'h11, 8'h01);
    check("su_oc", 8'(su_oc), 8'h01);
    access(1'b1, 8'h11, 8'h05); // Refused by the host
    check("oc_err", 8'(err), 8'h01);
    access(1'b1, 8'h12, 8'h28); // Top code sits above any input supply
    check("su_v", 8'(su_v), 8'h28);
    access(1'b1, 8'h12, 8'h13); // Forbidden code, never reaches the link
    check("v_err", 8'(err), 8'h01);
    rchk("su_v_rd", 8'h12, 8'h28);
    access(1'b1, 8'h13, 8'h02);
    check("sd_en", 8'({sd_en, bypass_select}), 8'h01);
    access(1'b1, 8'h14, 8'h35);
    check("sd_oc", 8'(sd_oc), 8'h05);
    check("mode", 8'(mode), 8'(PBR_MODE_PASS));
    check("pwr_flt", 8'({pwr, flt}), 8'h00);
    rchk("sd_cfg_rd", 8'h14, 8'h35);
    access(1'b1, 8'h10, 8'h00);
    check("su_en", 8'(su_en), 8'h00);
    access(1'b1, 8'h07, 8'h01);
    check("shut", 8'(shut), 8'h01);
    // Frozen ends must ignore a new request until the enable returns
    @(posedge i_clk);
    ce   <= 1'b0;
    pend <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    check("irq_frozen", 8'({link.irq_n_out, irq}), 8'h02);
    @(posedge i_clk);
    ce <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    check("irq_pin", 8'({link.irq_n_out, irq}), 8'h01);
    complete_run();
  end
endmodule
